// ==== rtl/shm_pkg.sv ====
// Shared constants and types for the sleep, hint and miscellaneous execute block
package shm_pkg;

    // Register bus geometry
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;

    // Register byte offsets
    localparam logic [7:0] OFF_CTRL       = 8'h00;
    localparam logic [7:0] OFF_STATUS     = 8'h04;
    localparam logic [7:0] OFF_IRQ_STATUS = 8'h08;
    localparam logic [7:0] OFF_IRQ_CLEAR  = 8'h0C;
    localparam logic [7:0] OFF_IRQ_ENABLE = 8'h10;
    localparam logic [7:0] OFF_FAULT_CNT  = 8'h14;

    // Control register fields
    localparam int unsigned CTRL_W          = 3;
    localparam int unsigned CTRL_WAKE_PEND  = 0;
    localparam int unsigned CTRL_DEBUG_EN   = 1;
    localparam int unsigned CTRL_SWAP_EN    = 2;
    localparam logic [2:0]  CTRL_RESET      = 3'h0;

    // Status register fields
    localparam int unsigned STAT_EVENT      = 0;
    localparam int unsigned STAT_STATE_LO   = 1;
    localparam int unsigned STAT_STATE_HI   = 2;

    // Interrupt status, clear and enable layout
    localparam int unsigned IRQ_W           = 4;
    localparam int unsigned IRQ_FAULT       = 0;
    localparam int unsigned IRQ_WAKE        = 1;
    localparam int unsigned IRQ_SWAP        = 2;
    localparam int unsigned IRQ_EVENT_SKIP  = 3;
    localparam logic [3:0]  IRQ_RESET       = 4'h0;

    // Response codes
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Immediate, register index and fault counter widths
    localparam int unsigned NARROW_IMM_W = 8;
    localparam int unsigned WIDE_IMM_W   = 16;
    localparam int unsigned ADR_IMM_W    = 12;
    localparam int unsigned REG_IDX_W    = 4;
    localparam int unsigned FAULT_CNT_W  = 16;

    // Decoded operations from the instruction stream
    typedef enum logic [2:0] {
        OP_NOP      = 3'h0,
        OP_UNDEF    = 3'h1,
        OP_WAIT_EV  = 3'h2,
        OP_WAIT_IRQ = 3'h3,
        OP_YIELD    = 3'h4,
        OP_ADR      = 3'h5,
        OP_SEND_EV  = 3'h6
    } shm_op_t;

    typedef enum logic [1:0] {
        ST_RUN       = 2'h0,
        ST_EV_SLEEP  = 2'h1,
        ST_IRQ_SLEEP = 2'h2
    } shm_state_t;

endpackage

// ==== rtl/shm_sync.sv ====
// Two-flop synchroniser for levels arriving from outside the clock domain
`timescale 1ns/10ps
module shm_sync #(
    parameter int unsigned W = 1
) (
    input  wire logic         aclk,
    input  wire logic         aresetn,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    logic [W-1:0] stage1;

    // The first stage feeds only the second one
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            stage1 <= '0;
            q      <= '0;
        end else begin
            stage1 <= d;
            q      <= stage1;
        end
    end

endmodule

// ==== rtl/shm_exec.sv ====
// Execute unit for undefined, wait, hint, send-event and PC-relative address operations
//
// What this block does
// - Narrow undefined-op immediate (8 bits, 0..255) is ignored by execution.
// - Wide undefined-op immediate (16 bits, 0..65535) is ignored by execution.
// - Undefined op always raises the usage fault, whatever its immediate.
// - Wait-for-event with event bit clear suspends until a wake condition.
// - Wait-for-event wakes on an exception not masked by masks or priority.
// - Wait-for-event wakes on a new pending exception when wake-on-pending set.
// - Wait-for-event wakes on a peripheral event or another core's send-event.
// - Both waits wake on a debug entry request while debug is enabled.
// - Wait-for-event with event bit set clears it and continues at once.
// - Wait-for-interrupt suspends until an unmasked interrupt is taken.
// - Wait-for-interrupt also wakes on an interrupt masked only by priority mask.
// - Wait, hint and address ops leave condition flags unchanged.
// - Task-swap hint may request a thread swap, or act as no operation.
// - Address op writes program counter plus or minus the immediate to the destination.
//
// Chosen here: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/10ps
module shm_exec (
    input  wire logic                           aclk,
    input  wire logic                           aresetn,
    // Instruction stream
    input  wire logic                           instr_valid,
    output logic                                instr_ready,
    input  wire logic [2:0]                     instr_op,
    input  wire logic                           instr_wide,
    input  wire logic [15:0]                    instr_imm,
    input  wire logic                           instr_sub,
    input  wire logic [3:0]                     instr_rd,
    input  wire logic [31:0]                    instr_pc,
    // Results
    output logic                                done,
    output logic                                usage_fault_exception,
    output logic                                rd_we,
    output logic [3:0]                          rd_idx,
    output logic [31:0]                         rd_data,
    output logic                                flags_we,
    output logic                                task_swap_req,
    output logic                                send_event_out,
    output logic                                sleeping,
    // Wake sources from the core
    input  wire logic                           exc_unmasked,
    input  wire logic                           exc_new_pending,
    input  wire logic                           irq_taken,
    input  wire logic                           irq_pend_priority_mask_bit,
    input  wire logic                           send_event_in,
    // Wake sources from pins
    input  wire logic                           periph_event,
    input  wire logic                           debug_req,
    // Register bus
    input  wire logic [7:0]                     s_axi_awaddr,
    input  wire logic                           s_axi_awvalid,
    output logic                                s_axi_awready,
    input  wire logic [31:0]                    s_axi_wdata,
    input  wire logic [3:0]                     s_axi_wstrb,
    input  wire logic                           s_axi_wvalid,
    output logic                                s_axi_wready,
    output logic [1:0]                          s_axi_bresp,
    output logic                                s_axi_bvalid,
    input  wire logic                           s_axi_bready,
    input  wire logic [7:0]                     s_axi_araddr,
    input  wire logic                           s_axi_arvalid,
    output logic                                s_axi_arready,
    output logic [31:0]                         s_axi_rdata,
    output logic [1:0]                          s_axi_rresp,
    output logic                                s_axi_rvalid,
    input  wire logic                           s_axi_rready,
    output logic                                irq
);

    shm_pkg::shm_state_t                state;
    shm_pkg::shm_state_t                next_state;
    logic                               event_reg;
    logic [shm_pkg::CTRL_W-1:0]         ctrl;
    logic [shm_pkg::IRQ_W-1:0]          irq_status;
    logic [shm_pkg::IRQ_W-1:0]          irq_enable;
    logic [shm_pkg::FAULT_CNT_W-1:0]    fault_cnt;
    logic [1:0]                         pin_sync;
    logic                               periph_prev;
    logic                               periph_rise;
    logic                               debug_wake;
    logic                               accept;
    logic                               event_set;
    logic                               event_clear;
    logic                               ev_wake;
    logic                               irq_wake;
    logic                               wake;
    logic                               aw_held;
    logic                               w_held;
    logic [7:0]                         aw_addr;
    logic [31:0]                        w_data;
    logic [3:0]                         w_strb;
    logic                               do_write;
    logic [shm_pkg::IRQ_W-1:0]          irq_clear;
    logic [shm_pkg::IRQ_W-1:0]          irq_events;

    // Byte-lane merge used by the control and interrupt-enable registers
    function automatic logic [31:0] merge_lanes(
        input logic [31:0] old_val,
        input logic [31:0] new_val,
        input logic [3:0]  strb
    );
        logic [31:0] res;
        res = old_val;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = new_val[i*8 +: 8];
            end
        end
        return res;
    endfunction

    // Immediate is zero-extended, then added or subtracted
    function automatic logic [31:0] pc_rel(
        input logic [31:0]                  pc,
        input logic [shm_pkg::ADR_IMM_W-1:0] imm,
        input logic                         sub
    );
        logic [31:0] ext;
        ext = {{(32-shm_pkg::ADR_IMM_W){1'b0}}, imm};
        return sub ? (pc - ext) : (pc + ext);
    endfunction

    shm_sync #(
        .W (2)
    ) u_pin_sync (
        .aclk    (aclk),
        .aresetn (aresetn),
        .d       ({debug_req, periph_event}),
        .q       (pin_sync)
    );

    // Pulse-style peripheral events are caught on their rising edge
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            periph_prev <= 1'b0;
        end else begin
            periph_prev <= pin_sync[0];
        end
    end

    assign periph_rise = pin_sync[0] & ~periph_prev;
    assign debug_wake  = pin_sync[1] & ctrl[shm_pkg::CTRL_DEBUG_EN];

    // Sequencing

    assign instr_ready = (state == shm_pkg::ST_RUN);
    assign accept      = instr_valid & instr_ready;
    assign sleeping    = (state != shm_pkg::ST_RUN);

    // A pending event always lands in the event bit, so one path besides debug entry wakes the sleep
    assign event_set = periph_rise | send_event_in
        | exc_unmasked
        | (exc_new_pending & ctrl[shm_pkg::CTRL_WAKE_PEND])
        | (accept & (instr_op == shm_pkg::OP_SEND_EV));

    assign ev_wake  = (state == shm_pkg::ST_EV_SLEEP) & (event_reg | debug_wake);
    assign irq_wake = (state == shm_pkg::ST_IRQ_SLEEP)
        & (irq_taken | irq_pend_priority_mask_bit | debug_wake);
    assign wake     = ev_wake | irq_wake;

    // Consumed by a wait that finds it set, or by the sleep it ends
    assign event_clear = (accept & (instr_op == shm_pkg::OP_WAIT_EV) & event_reg)
        | ((state == shm_pkg::ST_EV_SLEEP) & event_reg);

    always_comb begin
        next_state = state;
        unique case (state)
            shm_pkg::ST_RUN: begin
                if (accept && instr_op == shm_pkg::OP_WAIT_EV && !event_reg) begin
                    next_state = shm_pkg::ST_EV_SLEEP;
                end else if (accept && instr_op == shm_pkg::OP_WAIT_IRQ) begin
                    next_state = shm_pkg::ST_IRQ_SLEEP;
                end
            end
            shm_pkg::ST_EV_SLEEP: begin
                if (ev_wake) begin
                    next_state = shm_pkg::ST_RUN;
                end
            end
            shm_pkg::ST_IRQ_SLEEP: begin
                if (irq_wake) begin
                    next_state = shm_pkg::ST_RUN;
                end
            end
            default: begin
                next_state = shm_pkg::ST_RUN;
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= shm_pkg::ST_RUN;
        end else begin
            state <= next_state;
        end
    end

    // Set wins over clear so an event racing the consuming wait is kept
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            event_reg <= 1'b0;
        end else if (event_set) begin
            event_reg <= 1'b1;
        end else if (event_clear) begin
            event_reg <= 1'b0;
        end
    end

    // Execute results, one cycle after acceptance or wake

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            done                  <= 1'b0;
            usage_fault_exception <= 1'b0;
            rd_we                 <= 1'b0;
            task_swap_req         <= 1'b0;
            send_event_out        <= 1'b0;
        end else begin
            // A wait that sleeps completes only when it leaves the sleep state
            done <= (accept && instr_op != shm_pkg::OP_WAIT_IRQ
                     && !(instr_op == shm_pkg::OP_WAIT_EV && !event_reg)) || wake;
            // Immediate deliberately not looked at: every form faults
            usage_fault_exception <= accept && instr_op == shm_pkg::OP_UNDEF;
            rd_we                 <= accept && instr_op == shm_pkg::OP_ADR;
            task_swap_req         <= accept && instr_op == shm_pkg::OP_YIELD
                                     && ctrl[shm_pkg::CTRL_SWAP_EN];
            send_event_out        <= accept && instr_op == shm_pkg::OP_SEND_EV;
        end
    end

    // Destination and sum hold until the next address op
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rd_idx  <= '0;
            rd_data <= '0;
        end else if (accept && instr_op == shm_pkg::OP_ADR) begin
            rd_idx  <= instr_rd;
            rd_data <= pc_rel(instr_pc, instr_imm[shm_pkg::ADR_IMM_W-1:0], instr_sub);
        end
    end

    // None of these operations touch the condition flags
    assign flags_we = 1'b0;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fault_cnt <= '0;
        end else if (accept && instr_op == shm_pkg::OP_UNDEF) begin
            fault_cnt <= fault_cnt + 1'b1;
        end
    end

    // Register bus: write channel

    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready  = !w_held && !s_axi_bvalid;
    assign do_write      = aw_held && w_held;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            aw_addr <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
        end else if (do_write) begin
            aw_held <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held <= 1'b0;
            w_data <= '0;
            w_strb <= '0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
        end else if (do_write) begin
            w_held <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= shm_pkg::RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            unique case (aw_addr)
                shm_pkg::OFF_CTRL,
                shm_pkg::OFF_IRQ_CLEAR,
                shm_pkg::OFF_IRQ_ENABLE: s_axi_bresp <= shm_pkg::RESP_OKAY;
                default:                 s_axi_bresp <= shm_pkg::RESP_SLVERR;
            endcase
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl <= shm_pkg::CTRL_RESET;
        end else if (do_write && aw_addr == shm_pkg::OFF_CTRL) begin
            ctrl <= shm_pkg::CTRL_W'(merge_lanes(32'(ctrl), w_data, w_strb));
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_enable <= shm_pkg::IRQ_RESET;
        end else if (do_write && aw_addr == shm_pkg::OFF_IRQ_ENABLE) begin
            irq_enable <= shm_pkg::IRQ_W'(merge_lanes(32'(irq_enable), w_data, w_strb));
        end
    end

    // Interrupts: sticky status, set wins over a simultaneous clear

    assign irq_clear = (do_write && aw_addr == shm_pkg::OFF_IRQ_CLEAR && w_strb[0])
                       ? w_data[shm_pkg::IRQ_W-1:0] : '0;

    always_comb begin
        irq_events                          = '0;
        irq_events[shm_pkg::IRQ_FAULT]      = accept && instr_op == shm_pkg::OP_UNDEF;
        irq_events[shm_pkg::IRQ_WAKE]       = wake;
        irq_events[shm_pkg::IRQ_SWAP]       = accept && instr_op == shm_pkg::OP_YIELD;
        irq_events[shm_pkg::IRQ_EVENT_SKIP] = accept && instr_op == shm_pkg::OP_WAIT_EV && event_reg;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_status <= shm_pkg::IRQ_RESET;
        end else begin
            irq_status <= (irq_status & ~irq_clear) | irq_events;
        end
    end

    assign irq = |(irq_status & irq_enable);

    // Register bus: read channel, one read in flight

    assign s_axi_arready = !s_axi_rvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= '0;
            s_axi_rresp  <= shm_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= shm_pkg::RESP_OKAY;
            unique case (s_axi_araddr)
                shm_pkg::OFF_CTRL:       s_axi_rdata <= 32'(ctrl);
                shm_pkg::OFF_STATUS:     s_axi_rdata <= 32'({state, event_reg});
                shm_pkg::OFF_IRQ_STATUS: s_axi_rdata <= 32'(irq_status);
                shm_pkg::OFF_IRQ_ENABLE: s_axi_rdata <= 32'(irq_enable);
                shm_pkg::OFF_FAULT_CNT:  s_axi_rdata <= 32'(fault_cnt);
                // Clear register is write-only and reads as zero
                shm_pkg::OFF_IRQ_CLEAR:  s_axi_rdata <= '0;
                default: begin
                    s_axi_rdata <= '0;
                    s_axi_rresp <= shm_pkg::RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

endmodule

// ==== verification/shm_partner.sv ====
// Behavioural model of the core's wake sources and event pins
`timescale 1ns/10ps
module shm_partner (
    input  wire logic       aclk,
    input  wire logic       fire,
    input  wire logic [2:0] sel,
    output logic      [6:0] wake
);
    int cnt = 0;

    initial wake = 7'h00;

    // Pins from outside the clock domain stay up long enough to cross the synchroniser
    always @(posedge aclk) begin
        if (fire) begin
            wake <= 7'h01 << sel;
            cnt <= (sel > 3'h4) ? 4 : 1;
        end else if (cnt > 1) begin
            cnt <= cnt - 1;
        end else begin
            wake <= 7'h00;
        end
    end
endmodule

// ==== verification/shm_exec_monitor.sv ====
// Port checker for the execute block
`timescale 1ns/10ps
module shm_exec_monitor (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        instr_valid,
    input wire logic        instr_ready,
    input wire logic [2:0]  instr_op,
    input wire logic [15:0] instr_imm,
    input wire logic        instr_sub,
    input wire logic [3:0]  instr_rd,
    input wire logic [31:0] instr_pc,
    input wire logic        done,
    input wire logic        usage_fault_exception,
    input wire logic        rd_we,
    input wire logic [3:0]  rd_idx,
    input wire logic [31:0] rd_data,
    input wire logic        flags_we,
    input wire logic        task_swap_req,
    input wire logic        send_event_out,
    input wire logic        sleeping,
    input wire logic        irq_taken,
    input wire logic        irq_pend_priority_mask_bit,
    input wire logic        send_event_in,
    input wire logic        exc_unmasked
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    logic take;
    logic irq_wait;

    assign take = instr_valid && instr_ready;

    // Ports alone do not tell which wait is asleep, so remember the last one
    always_ff @(posedge aclk) begin
        if (!aresetn) irq_wait <= 1'b0;
        else if (take && instr_op == 3'h3) irq_wait <= 1'b1;
        else if (take && instr_op == 3'h2) irq_wait <= 1'b0;
    end

    undef_fault_a: assert property (take && instr_op == 3'h1 |=> usage_fault_exception && done)
        else $error("undefined op raised no fault");
    fault_cause_a: assert property (usage_fault_exception |-> $past(take && instr_op == 3'h1))
        else $error("fault without an undefined op");
    adr_sum_a: assert property (take && instr_op == 3'h5 |=> rd_we && rd_idx == $past(instr_rd)
        && rd_data == $past(instr_sub ? instr_pc - {20'h0, instr_imm[11:0]} : instr_pc + {20'h0, instr_imm[11:0]}))
        else $error("address result wrong");
    flags_kept_a: assert property (take |=> !flags_we [*3])
        else $error("flags written");
    irq_sleep_a: assert property (take && instr_op == 3'h3 |=> sleeping && !instr_ready)
        else $error("wait for interrupt did not sleep");
    irq_wake_a: assert property (sleeping && irq_wait && (irq_taken || irq_pend_priority_mask_bit)
        |=> !sleeping ##[0:1] done)
        else $error("interrupt did not wake");
    ev_wake_a: assert property (sleeping && !irq_wait && (send_event_in || exc_unmasked)
        |-> ##[1:2] !sleeping)
        else $error("event did not wake");
    swap_cause_a: assert property (task_swap_req |-> $past(take && instr_op == 3'h4))
        else $error("swap request without hint");
    send_pulse_a: assert property (take && instr_op == 3'h6 |=> send_event_out
        ##1 (!send_event_out || $past(take && instr_op == 3'h6)))
        else $error("send event pulse wrong");

    cover property (take && instr_op == 3'h2 ##1 sleeping);
    cover property (sleeping && irq_wait ##1 !sleeping);
    cover property (usage_fault_exception);
endmodule

bind shm_exec shm_exec_monitor shm_exec_monitor_inst (.aclk, .aresetn, .instr_valid, .instr_ready, .instr_op,
    .instr_imm, .instr_sub, .instr_rd, .instr_pc, .done, .usage_fault_exception, .rd_we, .rd_idx, .rd_data,
    .flags_we, .task_swap_req, .send_event_out, .sleeping, .irq_taken, .irq_pend_priority_mask_bit,
    .send_event_in, .exc_unmasked);

// ==== verification/tb_sleep_hint_and_misc_exec.sv ====
// Self-checking bench for the execute block
`timescale 1ns/10ps
module tb_sleep_hint_and_misc_exec;
    logic        aclk = 0, aresetn = 0, fire = 0, instr_valid = 0, instr_wide = 0, instr_sub = 0;
    logic [2:0]  instr_op = 0, sel = 0;
    logic [15:0] instr_imm = 0;
    logic [3:0]  instr_rd = 0, rd_idx;
    logic [31:0] instr_pc = 0, s_axi_wdata = 0, s_axi_rdata, rd_data, d;
    logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0;
    logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq, sleeping;
    logic        instr_ready, done, usage_fault_exception, rd_we, flags_we, task_swap_req, send_event_out;
    logic [1:0]  s_axi_bresp, s_axi_rresp, r;
    logic [6:0]  wake;
    int          n_fail = 0, check_count = 0, ev = 0, ist = 0, fcnt = 0, ctrl = 0;
    int          srcs[8] = '{0, 1, 2, 5, 6, 3, 4, 6};
    logic [15:0] uimm[4] = '{16'h0000, 16'h00FF, 16'hFFFF, 16'h1234};

    always #2.5 aclk = ~aclk;

    shm_exec shm_exec_inst (.aclk, .aresetn, .instr_valid, .instr_ready, .instr_op, .instr_wide, .instr_imm,
        .instr_sub, .instr_rd, .instr_pc, .done, .usage_fault_exception, .rd_we, .rd_idx, .rd_data, .flags_we,
        .task_swap_req, .send_event_out, .sleeping, .exc_unmasked(wake[0]), .exc_new_pending(wake[1]),
        .send_event_in(wake[2]), .irq_taken(wake[3]), .irq_pend_priority_mask_bit(wake[4]),
        .periph_event(wake[5]), .debug_req(wake[6]), .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .irq);
    shm_partner shm_partner_inst (.aclk, .fire, .sel, .wake);

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic test_done();
        $display("checks=%0d mismatches=%0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        int n;
        n = 0;
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        s_axi_bready <= 1;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 0;
        end while (!s_axi_bvalid && n < 50);
        chk(32'({!s_axi_bvalid, s_axi_bresp}),
            32'(a == shm_pkg::OFF_STATUS ? shm_pkg::RESP_SLVERR : shm_pkg::RESP_OKAY));
    endtask

    task automatic rd(input logic [7:0] a);
        int n;
        n = 0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        s_axi_rready <= 1;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 0;
        end while (!s_axi_rvalid && n < 50);
        d = s_axi_rdata;
        r = s_axi_rresp;
        chk({31'h0, !s_axi_rvalid}, 0);
    endtask

    // Only the always condition exists on this stream
    task automatic ex(input logic [2:0] op, input logic [15:0] imm);
        logic [5:0]  e;
        logic [31:0] p;
        logic        s;
        s = 1'($urandom);
        p = $urandom & 32'hFFFFFFFC;
        instr_op <= op;
        instr_imm <= imm;
        instr_sub <= s;
        instr_wide <= 1'($urandom);
        instr_pc <= p;
        instr_rd <= 4'($urandom_range(12, 0));
        instr_valid <= 1;
        @(posedge aclk);
        instr_valid <= 0;
        @(posedge aclk);
        e = 6'h20;
        if (op == 3'h1) begin e[4] = 1; fcnt++; ist |= 1; end
        if (op == 3'h5) e[3] = 1;
        if (op == 3'h4) begin e[2] = ctrl[2]; ist |= 4; end
        if (op == 3'h6) begin e[1] = 1; ev = 1; end
        if (op == 3'h2 && ev != 0) begin ev = 0; ist |= 8; end
        else if (op == 3'h2 || op == 3'h3) e = 6'h01;
        chk({26'h0, done, usage_fault_exception, rd_we, task_swap_req, send_event_out, sleeping}, {26'h0, e});
        if (op == 3'h5) chk(rd_data, s ? p - {16'h0, imm} : p + {16'h0, imm});
    endtask

    task automatic wk(input logic [2:0] s);
        int n;
        n = 0;
        sel <= s;
        fire <= 1;
        @(posedge aclk);
        fire <= 0;
        do begin
            @(posedge aclk);
            n++;
        end while (sleeping && n < 20);
        chk({31'h0, sleeping}, 0);
        ev = 0;
        ist |= 2;
        repeat (6) @(posedge aclk);
    endtask

    initial begin
        d = $urandom(32'h83AD052B);
        repeat (10) @(posedge aclk);
        aresetn <= 1;
        for (int i = 0; i < 7; i++) begin
            rd(8'(i * 4));
            chk(d, 0);
            chk(32'(r), i == 6 ? 32'(shm_pkg::RESP_SLVERR) : 32'(shm_pkg::RESP_OKAY));
        end
        ex(3'h4, 16'($urandom));
        wr(shm_pkg::OFF_CTRL, 7);
        ctrl = 7;
        rd(shm_pkg::OFF_CTRL);
        chk(d, 7);
        ex(3'h4, 16'($urandom));
        for (int i = 0; i < 4; i++) ex(3'h1, uimm[i]);
        repeat (8) ex(3'h5, 16'($urandom_range(4095, 0) | 1));
        ex(3'h0, 16'($urandom));
        ex(3'h6, 16'($urandom));
        ex(3'h2, 16'($urandom));
        for (int i = 0; i < 8; i++) begin
            ex(i < 5 ? 3'h2 : 3'h3, 16'($urandom));
            wk(3'(srcs[i]));
        end
        rd(shm_pkg::OFF_STATUS);
        chk(d, ev);
        wr(shm_pkg::OFF_STATUS, 32'h6);
        rd(shm_pkg::OFF_FAULT_CNT);
        chk(d, fcnt);
        rd(shm_pkg::OFF_IRQ_STATUS);
        chk(d, ist);
        wr(shm_pkg::OFF_IRQ_ENABLE, 32'hF);
        chk({31'h0, irq}, 1);
        wr(shm_pkg::OFF_IRQ_CLEAR, 32'hF);
        rd(shm_pkg::OFF_IRQ_STATUS);
        chk(d, 0);
        chk({31'h0, irq}, 0);
        ex(3'h1, 16'($urandom));
        wr(shm_pkg::OFF_IRQ_ENABLE, 32'hE);
        chk({31'h0, irq}, 0);
        wr(shm_pkg::OFF_IRQ_ENABLE, 32'h1);
        chk({31'h0, irq}, 1);
        test_done();
    end

    // Whole sequence needs well under a thousand cycles
    initial begin
        repeat (20000) @(posedge aclk);
        n_fail++;
        test_done();
    end
endmodule
